// file: rtl/crf_regfile.sv
`default_nettype none
// Overview of operation
// - Four 16-bit data words, two byte-split
// - Data words pair into two 32-bit operands
// - Two address pointers, pairable to 32 bits
// - Sixteen-bit frame base register
// - Sixteen-bit static base register
// - Twenty-bit vector table base register
// - Twenty-bit next fetch address register
// - User and interrupt stack pointers, flag-selected
// - Eleven-bit flag register of processor state
// - Carry flag latches ALU carry out
// - Zero flag reflects zero result
// - Sign flag reflects negative result
// - Bank flag selects register bank
// - Overflow flag reflects overflow
// - Interrupt flag gates maskable interrupts
// - Acknowledge clears interrupt enable flag
// - Stack flag zero means interrupt stack
// - Hardware ack or low trap clears stack flag
// - Accept interrupt above three-bit priority floor
module crf_regfile (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] core_wsel,
    input wire logic [31:0] core_wdata,
    input wire logic core_fetch_we,
    input wire logic [19:0] core_fetch_next,
    input wire logic flag_c_we,
    input wire logic alu_carry,
    input wire logic flag_zs_we,
    input wire logic [15:0] alu_result,
    input wire logic alu_byte,
    input wire logic flag_o_we,
    input wire logic alu_overflow,
    input wire logic irq_req,
    input wire logic irq_maskable,
    input wire logic [2:0] irq_level,
    input wire logic trap_exec,
    input wire logic [5:0] trap_num,
    output logic irq_accept,
    output logic [31:0] wide_pair_low,
    output logic [31:0] wide_pair_high,
    output logic [31:0] address_pointer_pair,
    output logic [15:0] active_stack_pointer,
    output logic bank_select,
    output logic [10:0] cpu_flags
);
    logic [15:0] data_word_reg [4];
    logic [15:0] aptr_reg [2];
    logic [15:0] frame_base_reg;
    logic [15:0] static_base_reg;
    logic [19:0] vector_table_base_reg;
    logic [19:0] next_fetch_pointer_reg;
    logic [15:0] user_stack_pointer_reg;
    logic [15:0] irq_stack_pointer_reg;
    logic [10:0] flags_reg;
    logic [10:0] flags_next;
    logic [5:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic bus_we;
    logic [5:0] ar_sel;
    logic [31:0] rd_word;
    logic ack;
    logic [15:0] res_msk;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // AXI4-Lite write path: address and data taken in either order.
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign bus_we = aw_held_reg && w_held_reg;
    assign s_axi_bresp = 2'h0;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;
    assign ar_sel = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            awaddr_reg <= 6'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (bus_we) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Unmapped reads return zero with an OKAY response.
    always_comb begin
        rd_word = 32'h00000000;
        unique case (ar_sel)
            crf_pkg::ADDR_DATA0: rd_word[15:0] = data_word_reg[0];
            crf_pkg::ADDR_DATA1: rd_word[15:0] = data_word_reg[1];
            crf_pkg::ADDR_DATA2: rd_word[15:0] = data_word_reg[2];
            crf_pkg::ADDR_DATA3: rd_word[15:0] = data_word_reg[3];
            crf_pkg::ADDR_APTR0: rd_word[15:0] = aptr_reg[0];
            crf_pkg::ADDR_APTR1: rd_word[15:0] = aptr_reg[1];
            crf_pkg::ADDR_FRAME: rd_word[15:0] = frame_base_reg;
            crf_pkg::ADDR_STATIC: rd_word[15:0] = static_base_reg;
            crf_pkg::ADDR_VTBASE: rd_word[19:0] = vector_table_base_reg;
            crf_pkg::ADDR_FETCH: rd_word[19:0] = next_fetch_pointer_reg;
            crf_pkg::ADDR_USP: rd_word[15:0] = user_stack_pointer_reg;
            crf_pkg::ADDR_ISP: rd_word[15:0] = irq_stack_pointer_reg;
            crf_pkg::ADDR_FLAGS: rd_word[10:0] = flags_reg;
            crf_pkg::ADDR_STATUS: rd_word[15:0] = active_stack_pointer;
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++) begin
                data_word_reg[i] <= crf_pkg::RST_WORD;
            end
            aptr_reg[0] <= crf_pkg::RST_WORD;
            aptr_reg[1] <= crf_pkg::RST_WORD;
        end else if (bus_we && awaddr_reg[5:4] == 2'h0) begin
            data_word_reg[awaddr_reg[3:2]] <= 16'(merge(
                {16'h0000, data_word_reg[awaddr_reg[3:2]]},
                wdata_reg, wstrb_reg));
        end else if (bus_we && awaddr_reg == crf_pkg::ADDR_APTR0) begin
            aptr_reg[0] <= 16'(merge({16'h0000, aptr_reg[0]}, wdata_reg,
                wstrb_reg));
        end else if (bus_we && awaddr_reg == crf_pkg::ADDR_APTR1) begin
            aptr_reg[1] <= 16'(merge({16'h0000, aptr_reg[1]}, wdata_reg,
                wstrb_reg));
        end else begin
            unique case (crf_pkg::crf_wsel_e'(core_wsel))
                crf_pkg::CRF_W_D0: data_word_reg[0] <= core_wdata[15:0];
                crf_pkg::CRF_W_D1: data_word_reg[1] <= core_wdata[15:0];
                crf_pkg::CRF_W_D2: data_word_reg[2] <= core_wdata[15:0];
                crf_pkg::CRF_W_D3: data_word_reg[3] <= core_wdata[15:0];
                crf_pkg::CRF_W_D0_HI: data_word_reg[0][15:8] <=
                    core_wdata[7:0];
                crf_pkg::CRF_W_D0_LO: data_word_reg[0][7:0] <=
                    core_wdata[7:0];
                crf_pkg::CRF_W_D1_HI: data_word_reg[1][15:8] <=
                    core_wdata[7:0];
                crf_pkg::CRF_W_D1_LO: data_word_reg[1][7:0] <=
                    core_wdata[7:0];
                crf_pkg::CRF_W_PAIR_LOW: begin
                    data_word_reg[2] <= core_wdata[31:16];
                    data_word_reg[0] <= core_wdata[15:0];
                end
                crf_pkg::CRF_W_PAIR_HIGH: begin
                    data_word_reg[3] <= core_wdata[31:16];
                    data_word_reg[1] <= core_wdata[15:0];
                end
                crf_pkg::CRF_W_APTR0: aptr_reg[0] <= core_wdata[15:0];
                crf_pkg::CRF_W_APTR1: aptr_reg[1] <= core_wdata[15:0];
                crf_pkg::CRF_W_APTR_PAIR: begin
                    aptr_reg[1] <= core_wdata[31:16];
                    aptr_reg[0] <= core_wdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    assign wide_pair_low = {data_word_reg[2], data_word_reg[0]};
    assign wide_pair_high = {data_word_reg[3], data_word_reg[1]};
    assign address_pointer_pair = {aptr_reg[1], aptr_reg[0]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_base_reg <= crf_pkg::RST_WORD;
            static_base_reg <= crf_pkg::RST_WORD;
            vector_table_base_reg <= crf_pkg::RST_ADDR20;
        end else if (bus_we) begin
            if (awaddr_reg == crf_pkg::ADDR_STATIC) begin
                static_base_reg <= 16'(merge({16'h0000, static_base_reg},
                    wdata_reg, wstrb_reg));
            end
            if (awaddr_reg == crf_pkg::ADDR_FRAME) begin
                frame_base_reg <= 16'(merge({16'h0000, frame_base_reg},
                    wdata_reg, wstrb_reg));
            end
            if (awaddr_reg == crf_pkg::ADDR_VTBASE) begin
                vector_table_base_reg <= 20'(merge(
                    {12'h000, vector_table_base_reg}, wdata_reg,
                    wstrb_reg));
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            next_fetch_pointer_reg <= crf_pkg::RST_ADDR20;
        end else if (bus_we && awaddr_reg == crf_pkg::ADDR_FETCH) begin
            next_fetch_pointer_reg <= 20'(merge(
                {12'h000, next_fetch_pointer_reg}, wdata_reg, wstrb_reg));
        end else if (core_fetch_we) begin
            next_fetch_pointer_reg <= core_fetch_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            user_stack_pointer_reg <= crf_pkg::RST_WORD;
            irq_stack_pointer_reg <= crf_pkg::RST_WORD;
        end else if (bus_we && awaddr_reg == crf_pkg::ADDR_USP) begin
            user_stack_pointer_reg <= 16'(merge(
                {16'h0000, user_stack_pointer_reg}, wdata_reg, wstrb_reg));
        end else if (bus_we && awaddr_reg == crf_pkg::ADDR_ISP) begin
            irq_stack_pointer_reg <= 16'(merge(
                {16'h0000, irq_stack_pointer_reg}, wdata_reg, wstrb_reg));
        end else if (core_wsel == 4'(crf_pkg::CRF_W_SP)) begin
            if (flags_reg[crf_pkg::FLG_U]) begin
                user_stack_pointer_reg <= core_wdata[15:0];
            end else begin
                irq_stack_pointer_reg <= core_wdata[15:0];
            end
        end
    end

    assign active_stack_pointer = flags_reg[crf_pkg::FLG_U] ?
        user_stack_pointer_reg : irq_stack_pointer_reg;
    assign bank_select = flags_reg[crf_pkg::FLG_B];
    assign cpu_flags = flags_reg;

    assign irq_accept = irq_req && (!irq_maskable ||
        flags_reg[crf_pkg::FLG_I]) &&
        (irq_level > flags_reg[crf_pkg::FLG_IPL_HI:crf_pkg::FLG_IPL_LO]);
    assign ack = irq_accept;
    assign res_msk = alu_byte ? 16'h00ff : 16'hffff;

    always_comb begin
        flags_next = flags_reg;
        if (bus_we && awaddr_reg == crf_pkg::ADDR_FLAGS) begin
            flags_next = 11'(merge({21'h000000, flags_reg}, wdata_reg,
                wstrb_reg));
        end
        if (flag_c_we) begin
            flags_next[crf_pkg::FLG_C] = alu_carry;
        end
        if (flag_zs_we) begin
            flags_next[crf_pkg::FLG_Z] = (alu_result & res_msk) == 16'h0000;
            flags_next[crf_pkg::FLG_S] = alu_byte ? alu_result[7] :
                alu_result[15];
        end
        if (flag_o_we) begin
            flags_next[crf_pkg::FLG_O] = alu_overflow;
        end
        if (ack) begin
            flags_next[crf_pkg::FLG_I] = 1'b0;
        end
        if (ack || (trap_exec && trap_num <= crf_pkg::TRAP_ISTACK_MAX)) begin
            flags_next[crf_pkg::FLG_U] = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg <= crf_pkg::RST_FLAGS;
        end else begin
            flags_reg <= flags_next;
        end
    end

    a_ack_clears_i: assert property (
        @(posedge aclk) disable iff (!aresetn)
        irq_accept |=> !cpu_flags[crf_pkg::FLG_I])
        else $error("Interrupt enable not cleared on acknowledge.");
    a_ack_clears_u: assert property (
        @(posedge aclk) disable iff (!aresetn)
        irq_accept |=> !cpu_flags[crf_pkg::FLG_U])
        else $error("Stack select not cleared on acknowledge.");
    a_trap_clears_u: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (trap_exec && trap_num < 6'h20) |=> !cpu_flags[crf_pkg::FLG_U])
        else $error("Stack select not cleared by low trap.");
    a_mask_blocks: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (irq_maskable && !cpu_flags[crf_pkg::FLG_I]) |-> !irq_accept)
        else $error("Masked interrupt accepted.");
    a_floor_blocks: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (irq_level <= cpu_flags[10:8]) |-> !irq_accept)
        else $error("Interrupt at or below floor accepted.");
    a_zero_flag: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (flag_zs_we && !alu_byte && !bus_we) |=>
        cpu_flags[crf_pkg::FLG_Z] == ($past(alu_result) == 16'h0000))
        else $error("Zero flag wrong.");
    a_sign_flag: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (flag_zs_we && !alu_byte && !bus_we) |=>
        cpu_flags[crf_pkg::FLG_S] == $past(alu_result[15]))
        else $error("Sign flag wrong.");
    a_carry_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!flag_c_we && !bus_we) |=> $stable(cpu_flags[crf_pkg::FLG_C]))
        else $error("Carry changed without update.");
    a_stack_sel: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (core_wsel == 4'(crf_pkg::CRF_W_SP) && !bus_we && !irq_accept &&
        !trap_exec) |=> active_stack_pointer == $past(core_wdata[15:0]))
        else $error("Stack write missed the selected pointer.");
endmodule : crf_regfile
`default_nettype wire

// file: shared/crf_pkg.sv
`default_nettype none
package crf_pkg;
    // Register byte addresses on the AXI4-Lite slave.
    localparam logic [5:0] ADDR_DATA0 = 6'h00;
    localparam logic [5:0] ADDR_DATA1 = 6'h04;
    localparam logic [5:0] ADDR_DATA2 = 6'h08;
    localparam logic [5:0] ADDR_DATA3 = 6'h0c;
    localparam logic [5:0] ADDR_APTR0 = 6'h10;
    localparam logic [5:0] ADDR_APTR1 = 6'h14;
    localparam logic [5:0] ADDR_FRAME = 6'h18;
    localparam logic [5:0] ADDR_STATIC = 6'h1c;
    localparam logic [5:0] ADDR_VTBASE = 6'h20;
    localparam logic [5:0] ADDR_FETCH = 6'h24;
    localparam logic [5:0] ADDR_USP = 6'h28;
    localparam logic [5:0] ADDR_ISP = 6'h2c;
    localparam logic [5:0] ADDR_FLAGS = 6'h30;
    localparam logic [5:0] ADDR_STATUS = 6'h34;
    // Flag bit positions inside cpu_flags.
    localparam int FLG_C = 0;
    localparam int FLG_D = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_S = 3;
    localparam int FLG_B = 4;
    localparam int FLG_O = 5;
    localparam int FLG_I = 6;
    localparam int FLG_U = 7;
    localparam int FLG_IPL_LO = 8;
    localparam int FLG_IPL_HI = 10;
    // Values after reset.
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [19:0] RST_ADDR20 = 20'h00000;
    localparam logic [10:0] RST_FLAGS = 11'h000;
    // Highest trap number that also switches to the interrupt stack.
    localparam logic [5:0] TRAP_ISTACK_MAX = 6'h1f;
    // Write selectors of the core update port.
    typedef enum logic [3:0] {
        CRF_W_NONE, CRF_W_D0, CRF_W_D1, CRF_W_D2, CRF_W_D3, CRF_W_D0_HI,
        CRF_W_D0_LO, CRF_W_D1_HI, CRF_W_D1_LO, CRF_W_PAIR_LOW,
        CRF_W_PAIR_HIGH, CRF_W_APTR0, CRF_W_APTR1, CRF_W_APTR_PAIR,
        CRF_W_SP
    } crf_wsel_e;
endpackage : crf_pkg
`default_nettype wire

// file: sim/crf_regfile_tb.sv
`default_nettype none
module crf_regfile_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [5:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } crf_row_s;
    // Debug bit kept zero.
    // Bits above each register's width are written nonzero and must vanish.
    localparam crf_row_s rows [0:12] = '{
        '{crf_pkg::ADDR_DATA0, 32'hffff1234, 32'h00001234},
        '{crf_pkg::ADDR_DATA1, 32'ha5a55678, 32'h00005678},
        '{crf_pkg::ADDR_DATA2, 32'hffff9abc, 32'h00009abc},
        '{crf_pkg::ADDR_DATA3, 32'hffffdef0, 32'h0000def0},
        '{crf_pkg::ADDR_APTR0, 32'hffff1111, 32'h00001111},
        '{crf_pkg::ADDR_APTR1, 32'hffff2222, 32'h00002222},
        '{crf_pkg::ADDR_FRAME, 32'hffff3333, 32'h00003333},
        '{crf_pkg::ADDR_STATIC, 32'hffff4444, 32'h00004444},
        '{crf_pkg::ADDR_VTBASE, 32'hfff9abcd, 32'h0009abcd},
        '{crf_pkg::ADDR_FETCH, 32'hfff12345, 32'h00012345},
        '{crf_pkg::ADDR_USP, 32'hffff5555, 32'h00005555},
        '{crf_pkg::ADDR_ISP, 32'hffff6666, 32'h00006666},
        '{crf_pkg::ADDR_FLAGS, 32'hfffff7fd, 32'h000007fd}};
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [5:0] s_axi_awaddr, s_axi_araddr, trap_num;
    logic [31:0] s_axi_wdata, s_axi_rdata, core_wdata, wide_pair_low;
    logic [31:0] wide_pair_high, address_pointer_pair, rd;
    logic [3:0] s_axi_wstrb, core_wsel;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic core_fetch_we, flag_c_we, alu_carry, flag_zs_we, alu_byte;
    logic flag_o_we, alu_overflow, irq_req, irq_maskable, trap_exec;
    logic irq_accept, bank_select;
    logic [19:0] core_fetch_next;
    logic [15:0] alu_result, active_stack_pointer;
    logic [2:0] irq_level;
    logic [10:0] cpu_flags;
    int n_fail = 0;
    int comparisons = 0;
    logic [3:0] strb_use = 4'hf;

    crf_regfile uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .core_wsel(core_wsel), .core_wdata(core_wdata),
        .core_fetch_we(core_fetch_we), .core_fetch_next(core_fetch_next),
        .flag_c_we(flag_c_we), .alu_carry(alu_carry),
        .flag_zs_we(flag_zs_we), .alu_result(alu_result),
        .alu_byte(alu_byte), .flag_o_we(flag_o_we),
        .alu_overflow(alu_overflow), .irq_req(irq_req),
        .irq_maskable(irq_maskable), .irq_level(irq_level),
        .trap_exec(trap_exec), .trap_num(trap_num),
        .irq_accept(irq_accept), .wide_pair_low(wide_pair_low),
        .wide_pair_high(wide_pair_high),
        .address_pointer_pair(address_pointer_pair),
        .active_stack_pointer(active_stack_pointer),
        .bank_select(bank_select), .cpu_flags(cpu_flags));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic finish_test;
        $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Ready is combinational, so it is judged at the falling edge, where
    // it has settled, and the handshake completes at the next rising edge.
    task automatic axi_write(input logic [5:0] a, input logic [31:0] d);
        logic aw_hs, w_hs, b_hs;
        int n;
        b_hs = 1'b0;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= strb_use;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_hs && n < 100) begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (b_hs) s_axi_bready <= 1'b0;
            n++;
        end
        if (!b_hs) n_fail++;
    endtask : axi_write

    task automatic axi_read(input logic [5:0] a, output logic [31:0] d);
        logic ar_hs, r_hs;
        int n;
        r_hs = 1'b0;
        n = 0;
        d = 32'hxxxxxxxx;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_hs && n < 100) begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid;
            if (r_hs) d = s_axi_rdata;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (r_hs) s_axi_rready <= 1'b0;
            n++;
        end
        if (!r_hs) n_fail++;
    endtask : axi_read

    task automatic alu_step(input logic [2:0] we, input logic c,
        input logic [15:0] r, input logic b, input logic o,
        input logic [10:0] exp);
        @(posedge aclk);
        flag_c_we <= we[2];
        flag_zs_we <= we[1];
        flag_o_we <= we[0];
        alu_carry <= c;
        alu_result <= r;
        alu_byte <= b;
        alu_overflow <= o;
        @(posedge aclk);
        flag_c_we <= 1'b0;
        flag_zs_we <= 1'b0;
        flag_o_we <= 1'b0;
        @(negedge aclk);
        check({21'h0, cpu_flags}, {21'h0, exp});
    endtask : alu_step

    task automatic event_step(input logic irq, input logic m,
        input logic [2:0] lv, input logic trap, input logic [5:0] tn,
        input logic acc, input logic [10:0] exp);
        @(posedge aclk);
        irq_req <= irq;
        irq_maskable <= m;
        irq_level <= lv;
        trap_exec <= trap;
        trap_num <= tn;
        @(negedge aclk);
        check({31'h0, irq_accept}, {31'h0, acc});
        @(posedge aclk);
        irq_req <= 1'b0;
        trap_exec <= 1'b0;
        @(negedge aclk);
        check({21'h0, cpu_flags}, {21'h0, exp});
    endtask : event_step

    task automatic core_write(input logic [3:0] sel, input logic [31:0] d);
        @(posedge aclk);
        core_wsel <= sel;
        core_wdata <= d;
        @(posedge aclk);
        core_wsel <= crf_pkg::CRF_W_NONE;
        @(negedge aclk);
    endtask : core_write

    initial begin
        #500000;
        n_fail++;
        finish_test();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= '0;
        {s_axi_arvalid, s_axi_rready, core_fetch_we, flag_c_we} <= '0;
        {alu_carry, flag_zs_we, alu_byte, flag_o_we, alu_overflow} <= '0;
        {irq_req, irq_maskable, trap_exec, irq_level, trap_num} <= '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
        {core_wsel, core_wdata, core_fetch_next, alu_result} <= '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            axi_read(rows[i].addr, rd);
            check(rd, 32'h0);
        end
        foreach (rows[i]) axi_write(rows[i].addr, rows[i].wdata);
        foreach (rows[i]) begin
            axi_read(rows[i].addr, rd);
            check(rd, rows[i].exp);
        end
        @(negedge aclk);
        check(wide_pair_low, 32'h9abc1234);
        check(wide_pair_high, 32'hdef05678);
        check(address_pointer_pair, 32'h22221111);
        check({16'h0, active_stack_pointer}, 32'h5555);
        check({31'h0, bank_select}, 32'h1);
        axi_write(6'h38, 32'h12345678);
        axi_read(6'h38, rd);
        check(rd, 32'h0);
        check({28'h0, s_axi_bresp, s_axi_rresp}, 32'h0);
        axi_write(crf_pkg::ADDR_STATUS, 32'h0);
        axi_read(crf_pkg::ADDR_STATUS, rd);
        check(rd, 32'h5555);
        axi_write(crf_pkg::ADDR_FLAGS, 32'h3c0);
        @(negedge aclk);
        check({31'h0, bank_select}, 32'h0);
        event_step(1'b1, 1'b1, 3'd3, 1'b0, 6'h0, 1'b0, 11'h3c0);
        event_step(1'b1, 1'b1, 3'd4, 1'b0, 6'h0, 1'b1, 11'h300);
        check({16'h0, active_stack_pointer}, 32'h6666);
        event_step(1'b1, 1'b1, 3'd7, 1'b0, 6'h0, 1'b0, 11'h300);
        event_step(1'b1, 1'b0, 3'd7, 1'b0, 6'h0, 1'b1, 11'h300);
        event_step(1'b1, 1'b0, 3'd3, 1'b0, 6'h0, 1'b0, 11'h300);
        axi_write(crf_pkg::ADDR_FLAGS, 32'h380);
        event_step(1'b0, 1'b0, 3'd0, 1'b1, 6'h20, 1'b0, 11'h380);
        event_step(1'b0, 1'b0, 3'd0, 1'b1, 6'h1f, 1'b0, 11'h300);
        axi_write(crf_pkg::ADDR_FLAGS, 32'h0);
        alu_step(3'b100, 1'b1, 16'h1234, 1'b0, 1'b0, 11'h001);
        alu_step(3'b010, 1'b0, 16'h0000, 1'b0, 1'b0, 11'h005);
        alu_step(3'b010, 1'b0, 16'h8000, 1'b0, 1'b0, 11'h009);
        alu_step(3'b010, 1'b0, 16'h0180, 1'b1, 1'b0, 11'h009);
        alu_step(3'b010, 1'b0, 16'h0100, 1'b1, 1'b0, 11'h005);
        alu_step(3'b001, 1'b0, 16'h0001, 1'b0, 1'b1, 11'h025);
        alu_step(3'b100, 1'b0, 16'h0001, 1'b0, 1'b1, 11'h024);
        core_write(crf_pkg::CRF_W_D0_LO, 32'h000000aa);
        check(wide_pair_low, 32'h9abc12aa);
        core_write(crf_pkg::CRF_W_D0_HI, 32'h00000055);
        check(wide_pair_low, 32'h9abc55aa);
        core_write(crf_pkg::CRF_W_PAIR_HIGH, 32'h13572468);
        check(wide_pair_high, 32'h13572468);
        core_write(crf_pkg::CRF_W_APTR_PAIR, 32'h0f0e0d0c);
        check(address_pointer_pair, 32'h0f0e0d0c);
        @(posedge aclk);
        core_fetch_we <= 1'b1;
        core_fetch_next <= 20'habcde;
        @(posedge aclk);
        core_fetch_we <= 1'b0;
        axi_read(crf_pkg::ADDR_FETCH, rd);
        check(rd, 32'h000abcde);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(crf_pkg::ADDR_DATA0, rd);
        check(rd, 32'h0);
        @(negedge aclk);
        check({21'h0, cpu_flags}, 32'h0);
        core_write(crf_pkg::CRF_W_PAIR_LOW, 32'h76543210);
        check(wide_pair_low, 32'h76543210);
        core_write(crf_pkg::CRF_W_D1_LO, 32'h000000c3);
        core_write(crf_pkg::CRF_W_D1_HI, 32'h0000003c);
        core_write(crf_pkg::CRF_W_D3, 32'h0000beef);
        check(wide_pair_high, 32'hbeef3cc3);
        core_write(crf_pkg::CRF_W_D0, 32'h0000a1a1);
        core_write(crf_pkg::CRF_W_D2, 32'h0000b2b2);
        check(wide_pair_low, 32'hb2b2a1a1);
        core_write(crf_pkg::CRF_W_APTR0, 32'h00000c0c);
        core_write(crf_pkg::CRF_W_APTR1, 32'h00000d0d);
        check(address_pointer_pair, 32'h0d0d0c0c);
        core_write(crf_pkg::CRF_W_SP, 32'h00007777);
        check({16'h0, active_stack_pointer}, 32'h7777);
        strb_use = 4'h2;
        axi_write(crf_pkg::ADDR_ISP, 32'h0000aa00);
        strb_use = 4'hf;
        axi_read(crf_pkg::ADDR_ISP, rd);
        check(rd, 32'h0000aa77);
        finish_test();
    end
endmodule : crf_regfile_tb
`default_nettype wire
